/* ash_dev_model.sv */
// ash_dev_model.sv: behavioural model of the 14-bit serial converter
// assumes: frame select and bit clock come from the host under test
`timescale 1ns/1ps
`default_nettype none
module ash_dev_model
(
   // link
   input  wire logic        bit_clock,
   input  wire logic        cs_n,
   output logic             serial_result_out,
   // bench side
   input  wire logic [13:0] sample,
   output logic             asleep
);
   logic [15:0] sh;
   logic        drv;
   int          nf;
   initial
   begin
      asleep = 1'b0;
      drv = 1'b0;
      nf = 0;
      sh = 16'h0000;
      serial_result_out = 1'b1;
   end
   // load result, first zero on select fall; dummy data while waking
   always @(negedge cs_n)
   begin
      sh = asleep ? 16'hFFFF : {2'b00, sample};
      nf = 0;
      drv = 1'b1;
      serial_result_out = sh[15];
   end
   // shift on falls, release at the sixteenth
   always @(negedge bit_clock)
   begin
      if (!cs_n)
      begin
         nf = nf + 1;
         if (drv && nf >= 16)
         begin
            drv = 1'b0;
            serial_result_out = ~serial_result_out; // released line modelled by inverting the last driven bit, not by floating
         end
         else if (drv)
         begin
            sh = sh << 1;
            serial_result_out = sh[15];
         end
      end
   end
   // select rise: release, sleep window, wake past tenth fall
   always @(posedge cs_n)
   begin
      if (drv)
         serial_result_out = ~serial_result_out;
      drv = 1'b0;
      if (nf >= 2 && nf < 10)
         asleep = 1'b1;
      else if (nf >= 10)
         asleep = 1'b0;
   end
endmodule // ash_dev_model
`default_nettype wire

/* ash_host.sv */
// ash_host.sv: host controller framing and clocking a 14-bit serial converter
// assumes: apb master on clk_sys; converter data pin is asynchronous and is
// synchronised here; the serial clock is divided down from clk_sys and driven out
`timescale 1ns/1ps
`default_nettype none
`include "ash_regs.svh"

// Overview of operation
// - frame pulse output wires straight to the converter chip select.
// - frame pulse is active low for the transfer.
// - a normal read clocks a 16-bit word.
// - power-down uses an 8-bit clock burst before frame release.
// - host makes the serial clock and drives it out.
// - frames start at equal intervals.
// - trigger interval is a whole number of serial clock periods.
// - a periodic timer or a start write starts each transfer; the timer sets the sample rate.
// - receive framing comes from the same frame pulse as transmit.
// - frame start waits for clock high, low, then high again.
// - optional fixed-width frame pulse lasts one serial clock period.
// - received word is stored right-justified.
// - after power-down a dummy read is needed; next read is valid.
module ash_host
   import ash_pkg::*;
(
   // system
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire ash_pkg::ash_addr_t paddr,
   input  wire ash_pkg::ash_word_t pwdata,
   output var  ash_pkg::ash_word_t prdata,
   output logic                  pready,
   output logic                  pslverr,
   // converter link
   output logic                  bit_clock,
   output logic                  transmit_frame_pulse_n,
   input  wire logic             serial_result_out
);
   import ash_pkg::*;

   // whole module state
   typedef struct packed
   {
      logic        run;
      logic        pd;
      logic        short_fs;
      logic [7:0]  div;
      logic [15:0] period;
      logic [7:0]  div_cnt;
      logic        sclk;
      logic [15:0] tmr;
      logic        pending;
      ash_state_e  st;
      logic [1:0]  seq;
      logic [4:0]  bits;
      logic [4:0]  len;
      logic [4:0]  caps;
      logic [1:0]  cap_d;
      logic        fs_n;
      logic [15:0] shreg;
      logic [15:0] data;
      logic        valid;
      logic        ovr;
      logic        asleep;
      logic        s1;
      logic        s2;
      ash_word_t   rdata;
   } ash_state_s;

   ash_state_s q;
   ash_state_s next_q;

   // decode helper shared by access decode and error answer
   function automatic logic reg_hit(input ash_addr_t a);
      reg_hit = (a == `ASH_CTRL_OFS) || (a == `ASH_PERIOD_OFS) ||
                (a == `ASH_STATUS_OFS) || (a == `ASH_DATA_OFS);
   endfunction

   logic [7:0]  half;
   logic        tick;
   logic        rise_ev;
   logic        fall_ev;
   logic [15:0] per_m1;
   logic        fire;
   logic        wr_acc;
   logic        rd_acc;
   logic        start_wr;
   logic        req;
   logic [15:0] new_word;
   logic        last_bit;
   logic        fall_in;
   logic        cap_done;

   // edge events of the divided serial clock
   always_comb
   begin
      half    = (q.div == 8'h00) ? 8'h01 : q.div;
      tick    = (q.div_cnt >= half - 8'h01);
      rise_ev = tick && !q.sclk;
      fall_ev = tick && q.sclk;
      per_m1  = (q.period == 16'h0000) ? 16'h0000 : q.period - 16'h0001;
      fire    = rise_ev && q.run && (q.tmr >= per_m1);
   end

   // apb access decode; zero wait states keep the master simple
   always_comb
   begin
      wr_acc   = psel && penable && pwrite && reg_hit(paddr);
      rd_acc   = psel && penable && !pwrite && reg_hit(paddr);
      start_wr = wr_acc && (paddr == `ASH_CTRL_OFS) && pwdata[`ASH_CTRL_START];
      req      = fire || start_wr;
      new_word = {q.shreg[14:0], q.s2};
      fall_in  = fall_ev && (q.st == ASH_XFER) && (q.bits < q.len);
      last_bit = fall_in && (q.bits == q.len - 5'h01);
      cap_done = q.cap_d[1] && (q.st == ASH_XFER) && (q.caps == q.len - 5'h01);
   end

   // next state
   always_comb
   begin
      next_q = q;
      // pin synchroniser, first stage read only by the second
      next_q.s1 = serial_result_out;
      next_q.s2 = q.s1;
      // falls in the frame, delayed to line up with the synchronised pin
      next_q.cap_d = {q.cap_d[0], fall_in};
      if (tick)
      begin
         next_q.div_cnt = 8'h00;
         next_q.sclk    = !q.sclk;
      end
      else
      begin
         next_q.div_cnt = q.div_cnt + 8'h01;
      end
      // equal spacing from one fixed period
      // periodic timer in whole serial periods
      // counting rises keeps triggers on a fixed edge
      if (rise_ev)
      begin
         if (!q.run || fire)
         begin
            next_q.tmr = 16'h0000;
         end
         else
         begin
            next_q.tmr = q.tmr + 16'h0001;
         end
      end
      // request queue; a trigger while busy is lost and flagged
      if (req)
      begin
         if (q.pending || (q.st != ASH_IDLE))
         begin
            next_q.ovr = 1'b1;
         end
         else
         begin
            next_q.pending = 1'b1;
         end
      end
      case (q.st)
         ASH_IDLE:
         begin
            if (q.pending)
            begin
               next_q.st  = ASH_SYNC;
               next_q.seq = 2'h0;
               next_q.len = q.pd ? `ASH_PD_BITS : `ASH_FULL_BITS;
            end
         end
         ASH_SYNC:
         begin
            // see high, low, high before framing
            if (rise_ev && (q.seq == 2'h0))
            begin
               next_q.seq = 2'h1;
            end
            else if (fall_ev && (q.seq == 2'h1))
            begin
               next_q.seq = 2'h2;
            end
            else if (rise_ev && (q.seq == 2'h2))
            begin
               next_q.fs_n    = 1'b0;
               next_q.bits    = 5'h00;
               next_q.caps    = 5'h00;
               next_q.pending = 1'b0;
               next_q.st      = ASH_XFER;
            end
         end
         ASH_XFER:
         begin
            // fixed-width pulse ends after one serial period
            if (q.short_fs && rise_ev)
            begin
               next_q.fs_n = 1'b1;
            end
            // capture window opened by the same frame pulse
            if (fall_in)
            begin
               next_q.bits = q.bits + 5'h01;
            end
            // frame released on the same clock edge as the last falling edge
            if (last_bit)
            begin
               next_q.fs_n = 1'b1;
            end
            // sample two clocks after each fall to cover the pin synchroniser;
            // without it a short half period reads the first bit stale
            if (q.cap_d[1])
            begin
               next_q.shreg = new_word;
               next_q.caps  = q.caps + 5'h01;
            end
            if (cap_done)
            begin
               next_q.st   = ASH_IDLE;
               if (q.len == `ASH_PD_BITS)
               begin
                  // short burst leaves the converter asleep
                  next_q.asleep = 1'b1;
               end
               else
               begin
                  // a full read wakes the converter and stores data; after sleep it is not marked valid
                  next_q.asleep = 1'b0;
                  next_q.data = new_word;
               end
            end
         end
         default:
         begin
            next_q.st = ASH_IDLE;
         end
      endcase
      // register reads; clearing valid yields to a new capture
      if (rd_acc && (paddr == `ASH_DATA_OFS))
      begin
         next_q.valid = 1'b0;
      end
      if (cap_done && (q.len == `ASH_FULL_BITS) && !q.asleep)
      begin
         next_q.valid = 1'b1;
      end
      // register writes
      if (wr_acc)
      begin
         case (paddr)
            `ASH_CTRL_OFS:
            begin
               next_q.run      = pwdata[`ASH_CTRL_RUN];
               next_q.pd       = pwdata[`ASH_CTRL_PD];
               next_q.short_fs = pwdata[`ASH_CTRL_SHORT];
               next_q.div      = pwdata[`ASH_CTRL_DIV_MSB:`ASH_CTRL_DIV_LSB];
            end
            `ASH_PERIOD_OFS:
            begin
               next_q.period = pwdata[15:0];
            end
            `ASH_STATUS_OFS:
            begin
               // write one clears overrun unless a new one lands now
               if (pwdata[`ASH_STAT_OVR] && !(req && (q.pending || (q.st != ASH_IDLE))))
               begin
                  next_q.ovr = 1'b0;
               end
            end
            default:
            begin
               next_q.ovr = next_q.ovr;
            end
         endcase
      end
      // read data latched in the setup cycle
      next_q.rdata = 32'h00000000;
      if (psel && !penable && !pwrite)
      begin
         case (paddr)
            `ASH_CTRL_OFS:
            begin
               next_q.rdata[`ASH_CTRL_RUN]                   = q.run;
               next_q.rdata[`ASH_CTRL_PD]                    = q.pd;
               next_q.rdata[`ASH_CTRL_SHORT]                 = q.short_fs;
               next_q.rdata[`ASH_CTRL_DIV_MSB:`ASH_CTRL_DIV_LSB] = q.div;
            end
            `ASH_PERIOD_OFS:
            begin
               next_q.rdata[15:0] = q.period;
            end
            `ASH_STATUS_OFS:
            begin
               next_q.rdata[`ASH_STAT_BUSY]   = (q.st != ASH_IDLE) || q.pending;
               next_q.rdata[`ASH_STAT_VALID]  = q.valid;
               next_q.rdata[`ASH_STAT_OVR]    = q.ovr;
               next_q.rdata[`ASH_STAT_ASLEEP] = q.asleep;
            end
            `ASH_DATA_OFS:
            begin
               next_q.rdata[15:0] = q.data;
            end
            default:
            begin
               next_q.rdata = 32'h00000000;
            end
         endcase
      end
   end

   // state register; constants only under reset
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         q          <= '0;
         q.div      <= `ASH_DIV_RST;
         q.period   <= `ASH_PERIOD_RST;
         q.st       <= ASH_IDLE;
         q.fs_n     <= 1'b1;
         q.len      <= `ASH_FULL_BITS;
      end
      else
      begin
         q <= next_q;
      end
   end

   // outputs
   assign prdata    = q.rdata;
   assign pready    = psel && penable;
   assign pslverr   = psel && penable && !reg_hit(paddr);
   assign bit_clock = q.sclk;
   // frame pulse goes straight to chip select
   assign transmit_frame_pulse_n = q.fs_n;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   sequence frame_open_s;
      $fell(q.fs_n);
   endsequence

   sequence frame_close_s;
      $rose(q.fs_n);
   endsequence

   frame_start_a: assert property (frame_open_s |-> $past(rise_ev) && $past(q.seq) == 2'h2)
      else $error("frame opened without high-low-high clock sequence");

   frame_len_a: assert property ((frame_close_s and !q.short_fs) |-> $past(q.bits) == q.len - 5'h01)
      else $error("frame released at wrong bit count");

   pd_burst_a: assert property ($rose(q.asleep) |-> $past(q.len) == `ASH_PD_BITS)
      else $error("sleep entered without an 8-bit burst");

   clock_runs_a: assert property (q.st == ASH_XFER |-> ##[1:260] $changed(q.sclk))
      else $error("serial clock stalled during a frame");

   timer_fire_a: assert property (fire |=> q.tmr == 16'h0000)
      else $error("timer did not restart at trigger");

   timer_edge_a: assert property ($changed(q.tmr) |-> $past(rise_ev) || $past(!q.run))
      else $error("timer moved off a serial rising edge");

   wake_dummy_a: assert property ($rose(q.valid) |-> !$past(q.asleep))
      else $error("data marked valid from a wake-up read");

   rx_window_a: assert property ((q.st == ASH_XFER) && !q.short_fs && (q.bits < q.len) |-> !q.fs_n)
      else $error("capture window open while frame inactive");

   short_pulse_a: assert property ((frame_open_s and q.short_fs) |-> ##[1:520] frame_close_s)
      else $error("short frame pulse not ended");

   valid_set_a: assert property (cap_done && q.len == `ASH_FULL_BITS && !q.asleep |=> q.valid)
      else $error("full read not reported valid");

endmodule // ash_host

`default_nettype wire

/* ash_pkg.sv */
// ash_pkg.sv: types shared by the serial converter host controller
// assumes: ash_regs.svh holds every number; this package holds only types
package ash_pkg;

   // frame sequencer states
   typedef enum logic [1:0]
   {
      ASH_IDLE,
      ASH_SYNC,
      ASH_XFER
   } ash_state_e;

   // apb address and data
   typedef logic [7:0]  ash_addr_t;
   typedef logic [31:0] ash_word_t;

endpackage

/* ash_regs.svh */
// ash_regs.svh: register offsets, field positions, reset values and link lengths
// assumes: included by the serial converter host controller and its package users
`ifndef ASH_REGS_SVH
`define ASH_REGS_SVH

// register byte offsets on the apb slave
`define ASH_CTRL_OFS      8'h00
`define ASH_PERIOD_OFS    8'h04
`define ASH_STATUS_OFS    8'h08
`define ASH_DATA_OFS      8'h0C

// control register fields
`define ASH_CTRL_RUN      0
`define ASH_CTRL_PD       1
`define ASH_CTRL_START    2
`define ASH_CTRL_SHORT    3
`define ASH_CTRL_DIV_LSB  8
`define ASH_CTRL_DIV_MSB  15

// status register fields
`define ASH_STAT_BUSY     0
`define ASH_STAT_VALID    1
`define ASH_STAT_OVR      2
`define ASH_STAT_ASLEEP   3

// reset values
`define ASH_DIV_RST       8'h05
`define ASH_PERIOD_RST    16'h0020

// serial clocks per frame
`define ASH_FULL_BITS     5'h10
`define ASH_PD_BITS       5'h08

`endif

/* test_adc_serial_host_reader.sv */
// test_adc_serial_host_reader.sv: self-checking bench for the converter host
// assumes: ash_host with apb slave; converter model on the link
`timescale 1ns/1ps
`default_nettype none
`include "ash_regs.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); n_fail++; end end
module test_adc_serial_host_reader;
   import ash_pkg::*;
   logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, bit_clock, frame_n, sdo, asleep;
   logic        pcs, pbk, fall_rise, last_err;
   logic [13:0] sample;
   ash_addr_t   paddr;
   ash_word_t   pwdata, prdata, q, exp_data;
   int          n_fail, n_compared, seed, cyc, last_start, interval, low_st, low_w, nfall, last_len, k;
   ash_host u_ash_host (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bit_clock(bit_clock), .transmit_frame_pulse_n(frame_n), .serial_result_out(sdo));
   // frame pulse wired straight to select
   ash_dev_model u_dev (.bit_clock(bit_clock), .cs_n(frame_n), .serial_result_out(sdo),
      .sample(sample), .asleep(asleep));
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // link monitor on pre-edge values, so no race with the design
   always @(posedge clk_sys)
   begin
      cyc++;
      if (pcs === 1'b1 && frame_n === 1'b0)
      begin
         fall_rise = bit_clock & ~pbk;
         interval = cyc - last_start;
         last_start = cyc;
         nfall = 0;
         low_st = cyc;
      end
      if (pcs === 1'b0 && pbk === 1'b1 && bit_clock === 1'b0)
         nfall++;
      if (pcs === 1'b0 && frame_n === 1'b1)
      begin
         last_len = nfall;
         low_w = cyc - low_st;
      end
      pcs = frame_n;
      pbk = bit_clock;
   end
   task automatic finish_test();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // one apb transfer: setup, access until pready, then an idle cycle
   task automatic apb(input logic wr, input ash_addr_t a, input ash_word_t d);
      int i;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge clk_sys);
         if (pready === 1'b1)
            break;
      end
      if (i >= 50)
      begin
         n_fail++;
         finish_test();
      end
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wait_cs(input logic v);
      int i;
      for (i = 0; frame_n !== v; i++)
      begin
         if (i > 3000)
         begin
            n_fail++;
            finish_test();
         end
         @(posedge clk_sys);
      end
   endtask
   task automatic wait_frame();
      int i;
      wait_cs(1'b0);
      wait_cs(1'b1);
      q = 32'h1;
      for (i = 0; q[`ASH_STAT_BUSY] !== 1'b0; i++)
      begin
         if (i > 300)
         begin
            n_fail++;
            finish_test();
         end
         apb(1'b0, `ASH_STATUS_OFS, 32'h0);
      end
   endtask
   function automatic ash_word_t ctl(input logic run, pd, st, sh, input logic [7:0] dv);
      ctl = 32'h0;
      ctl[`ASH_CTRL_RUN] = run;
      ctl[`ASH_CTRL_PD] = pd;
      ctl[`ASH_CTRL_START] = st;
      ctl[`ASH_CTRL_SHORT] = sh;
      ctl[`ASH_CTRL_DIV_MSB:`ASH_CTRL_DIV_LSB] = dv;
   endfunction
   function automatic ash_word_t stw(input logic v, o, a);
      stw = (32'(v) << `ASH_STAT_VALID) | (32'(o) << `ASH_STAT_OVR) | (32'(a) << `ASH_STAT_ASLEEP);
   endfunction
   // started full read with random result, checked end to end
   task automatic full_read(input logic [7:0] dv);
      sample = 14'($random(seed));
      exp_data = 32'({2'b00, sample});
      apb(1'b1, `ASH_CTRL_OFS, ctl(1'b0, 1'b0, 1'b1, 1'b0, dv));
      wait_frame();
      `CHK("len", 16, last_len)
      `CHK("fall on rise", 1'b1, fall_rise)
      apb(1'b0, `ASH_STATUS_OFS, 32'h0);
      `CHK("status", stw(1'b1, 1'b0, 1'b0), q)
      apb(1'b0, `ASH_DATA_OFS, 32'h0);
      `CHK("data", exp_data, q)
      apb(1'b0, `ASH_STATUS_OFS, 32'h0);
      `CHK("valid cleared", stw(1'b0, 1'b0, 1'b0), q)
   endtask
   initial
   begin
      seed = 3479;
      {n_fail, n_compared, cyc, last_start, interval, low_w, nfall, last_len} = '0;
      {psel, penable, pwrite, pcs, pbk, fall_rise} = '0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sample = 14'h0000;
      rst = 1'b1;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      `CHK("idle frame", 1'b1, frame_n)
      apb(1'b0, `ASH_CTRL_OFS, 32'h0);
      `CHK("ctrl rst", 32'(`ASH_DIV_RST) << `ASH_CTRL_DIV_LSB, q)
      apb(1'b0, `ASH_PERIOD_OFS, 32'h0);
      `CHK("period rst", 32'(`ASH_PERIOD_RST), q)
      apb(1'b0, 8'h10, 32'h0);
      `CHK("unmapped", 33'h100000000, {last_err, q})
      apb(1'b1, `ASH_PERIOD_OFS, 32'd24);
      for (k = 0; k < 3; k++)
         full_read(8'(2 + k % 2));
      // power-down burst, then dummy wake read, then valid read
      apb(1'b1, `ASH_CTRL_OFS, ctl(1'b0, 1'b1, 1'b1, 1'b0, 8'h02));
      wait_frame();
      `CHK("pd len", 8, last_len)
      `CHK("dev asleep", 1'b1, asleep)
      apb(1'b0, `ASH_STATUS_OFS, 32'h0);
      `CHK("asleep", stw(1'b0, 1'b0, 1'b1), q)
      apb(1'b0, `ASH_DATA_OFS, 32'h0);
      `CHK("data kept", exp_data, q)
      apb(1'b1, `ASH_CTRL_OFS, ctl(1'b0, 1'b0, 1'b1, 1'b0, 8'h02));
      wait_frame();
      `CHK("dev awake", 1'b0, asleep)
      apb(1'b0, `ASH_STATUS_OFS, 32'h0);
      `CHK("dummy", stw(1'b0, 1'b0, 1'b0), q)
      full_read(8'h02);
      // short frame lasts one serial period
      apb(1'b1, `ASH_CTRL_OFS, ctl(1'b0, 1'b0, 1'b1, 1'b1, 8'h03));
      wait_frame();
      `CHK("short width", 6, low_w)
      // start while busy is refused and flagged
      apb(1'b1, `ASH_CTRL_OFS, ctl(1'b0, 1'b0, 1'b1, 1'b0, 8'h02));
      wait_cs(1'b0);
      apb(1'b1, `ASH_CTRL_OFS, ctl(1'b0, 1'b0, 1'b1, 1'b0, 8'h02));
      wait_frame();
      apb(1'b0, `ASH_STATUS_OFS, 32'h0);
      `CHK("ovr", 1'b1, q[`ASH_STAT_OVR])
      apb(1'b1, `ASH_STATUS_OFS, 32'h1 << `ASH_STAT_OVR);
      apb(1'b0, `ASH_STATUS_OFS, 32'h0);
      `CHK("ovr clear", 1'b0, q[`ASH_STAT_OVR])
      // timer-paced frames at a whole number of serial periods
      apb(1'b1, `ASH_CTRL_OFS, ctl(1'b1, 1'b0, 1'b0, 1'b0, 8'h02));
      for (k = 0; k < 4; k++)
      begin
         wait_frame();
         if (k > 0)
            `CHK("interval", 24 * 4, interval)
         apb(1'b0, `ASH_DATA_OFS, 32'h0);
         `CHK("timed data", 32'({2'b00, sample}), q)
         sample = 14'($random(seed));
      end
      // stop the timer with one last started read
      apb(1'b1, `ASH_CTRL_OFS, ctl(1'b0, 1'b0, 1'b1, 1'b0, 8'h02));
      wait_frame();
      apb(1'b0, `ASH_DATA_OFS, 32'h0);
      `CHK("last data", 32'({2'b00, sample}), q)
      finish_test();
   end
endmodule // test_adc_serial_host_reader
`default_nettype wire
